/* File: hdl/disk_err_params.svh */
// Constants for the command error checker: register map, fields, codes, timing.
// Assumes a 250 MHz core clock; included by bare name where needed.
`ifndef DISK_ERR_PARAMS_SVH
`define DISK_ERR_PARAMS_SVH

// Register byte offsets
`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define OFS_LOG_HEAD    8'h08
`define OFS_LOG_POP     8'h0C

// Control register fields
`define CTRL_WP_BIT     0
`define CTRL_RUN_BIT    1
`define CTRL_FMT_BIT    2
`define CTRL_INHIB_BIT  3
`define CTRL_AVAIL_BIT  4
`define CTRL_ONLINE_BIT 5
`define CTRL_CLR_BIT    8
`define CTRL_RESET      5'h00

// Status register fields
`define ST_FAULT_BIT    0
`define ST_ONLINE_BIT   1
`define ST_VARIANT_BIT  2
`define ST_DISABLE_BIT  3
`define ST_LOST_BIT     4
`define ST_COUNT_LSB    8
`define LOG_VALID_BIT   31

// Error codes
`define EC_WP_ENABLE    8'h0F
`define EC_XFER_FAULT   8'h12
`define EC_FMT_576      8'h15
`define EC_VARIANT      8'h16
`define EC_VAR_SEEK     8'h17
`define EC_CYLINDER     8'h1A
`define EC_CTL_DROP     8'h1D
`define EC_CORR_OVF     8'h1E
`define EC_OVERRUN      8'h1F
`define EC_RECOV_LVL    8'h29
`define EC_SPINDLE      8'h2C
`define EC_SPIN_INHIB   8'h2E
`define EC_RUN_STOP     8'h2F
`define EC_MEM_REGION   8'h40
`define EC_RESP_TO      8'h41
`define EC_NOT_ONLINE   8'h42
`define EC_RW_READY     8'h43
`define EC_FMT_DISABLED 8'h44
`define EC_DISC_MOD     8'h47
`define EC_TOPO_BUSY    8'h49
`define EC_DRV_DISABLE  8'h4A
`define EC_WP_WRITE     8'h4E
`define EC_CLK_DROP     8'h4F

// Correction count limit per bank
`define CORR_LIMIT      9'h100

// Timing: figures in ns, counts derived at the 4 ns period
`define T_CLK_NS        4
`define DROP_NS         1000
`define DROP_CYC        ((`DROP_NS) / `T_CLK_NS)
`define RESP_TO_NS      1000000
`define RESP_TO_CYC     ((`RESP_TO_NS) / `T_CLK_NS)
`define CTL_TO_NS       100000
`define CTL_TO_CYC      ((`CTL_TO_NS) / `T_CLK_NS)

`endif

/* File: hdl/disk_err_pkg.sv */
// Types shared by the command error checker.
// Assumes nothing beyond a SystemVerilog compiler.
package disk_err_pkg;

	// Error class tag kept with each logged code
	typedef enum logic [2:0] {
		DRIVE_FAULT_CLASS  = 3'h0,
		TRANSMISSION_CLASS = 3'h1,
		PROTOCOL_CLASS     = 3'h2,
		WRITE_LOCK_CLASS   = 3'h3,
		DIAG_FAIL_CLASS    = 3'h4,
		UNCLASSED          = 3'h5
	} err_class_e;

	// Decoded level 2 command opcodes
	typedef enum logic [3:0] {
		OP_NOP         = 4'h0,
		OP_CHANGE_MODE = 4'h1,
		OP_SEEK        = 4'h2,
		OP_RECAL       = 4'h3,
		OP_ERR_RECOV   = 4'h4,
		OP_RUN         = 4'h5,
		OP_READ_MEM    = 4'h6,
		OP_DISCONNECT  = 4'h7,
		OP_TOPOLOGY    = 4'h8,
		OP_FMT_TRACK   = 4'h9,
		OP_FMT_SECT    = 4'hA,
		OP_GET_STATUS  = 4'hB
	} cmd_op_e;

endpackage

/* File: hdl/disk_cmd_error_checker.sv */
// Command validation and error classification with an APB error log.
// Assumes decoded commands on i_clk and raw gate/pulse/clock pins from outside.
//
// Chosen here: register access over APB and the register addresses.
`include "disk_err_params.svh"
`timescale 1ns/100ps
`default_nettype none

module disk_cmd_error_checker #(
	parameter int NUM_BANKS   = 8,
	parameter int MAX_CYL     = 1024,
	parameter int NUM_REGIONS = 4,
	parameter int MAX_RECOV   = 3,
	parameter int SUPP_VAR    = 1,
	parameter int LOG_DEPTH   = 4,
	parameter int RESP_TO_CYC = `RESP_TO_CYC,
	parameter int CTL_TO_CYC  = `CTL_TO_CYC,
	parameter int BW          = (NUM_BANKS > 1) ? $clog2(NUM_BANKS) : 1
) (
	input  wire logic                   i_clk,
	input  wire logic                   i_srst,
	input  wire logic                   i_psel,
	input  wire logic                   i_penable,
	input  wire logic                   i_pwrite,
	input  wire logic [7:0]             i_paddr,
	input  wire logic [31:0]            i_pwdata,
	output logic      [31:0]            o_prdata,
	output logic                        o_pready,
	output logic                        o_pslverr,
	input  wire logic                   i_cmd_valid,
	input  wire disk_err_pkg::cmd_op_e  i_cmd_op,
	input  wire logic [15:0]            i_cmd_arg,
	input  wire logic                   i_cmd_write_en,
	input  wire logic                   i_cmd_fmt576,
	input  wire logic                   i_drive_disable_bit,
	input  wire logic                   i_disconnect_modifier_bit,
	input  wire logic                   i_transfer_cmd_received,
	input  wire logic                   i_xfer_active,
	input  wire logic                   i_rw_ready,
	input  wire logic                   i_topo_busy,
	input  wire logic                   i_ctl_activity,
	input  wire logic                   i_resp_valid,
	input  wire logic                   i_resp_ready,
	input  wire logic                   i_corr_valid,
	input  wire logic [BW-1:0]          i_corr_bank,
	input  wire logic                   i_sector_pin,
	input  wire logic                   i_index_pin,
	input  wire logic                   i_wr_gate_pin,
	input  wire logic                   i_rd_gate_pin,
	input  wire logic                   i_ctl_clk_pin,
	input  wire logic                   i_dat_clk_pin,
	output logic                        o_fault,
	output logic                        o_online,
	output logic                        o_variant_mode,
	output logic                        o_drive_disabled,
	output logic                        o_resp_abort
);
	localparam int LW = $clog2(LOG_DEPTH);
	localparam int NSRC = 9;

	generate
		if (LOG_DEPTH < 2 || (1 << LW) != LOG_DEPTH || NUM_BANKS < 1 ||
		    MAX_CYL < 1 || RESP_TO_CYC < 2 || CTL_TO_CYC < 2) begin : g_bad
			$error("disk_cmd_error_checker: unsupported parameter values");
		end
	endgenerate

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: three stages, change taken when stages 2 and 3 agree
	logic [5:0] pin_raw;
	logic [5:0] s1_q, s2_q, s3_q, pin_q, pin_p_q;
	assign pin_raw = {i_dat_clk_pin, i_ctl_clk_pin, i_rd_gate_pin,
	                  i_wr_gate_pin, i_index_pin, i_sector_pin};

	genvar gp;
	generate
		for (gp = 0; gp < 6; gp++) begin : g_sync
			always_ff @(posedge i_clk) begin
				if (i_srst) begin
					s1_q[gp]    <= 1'b0;
					s2_q[gp]    <= 1'b0;
					s3_q[gp]    <= 1'b0;
					pin_q[gp]   <= 1'b0;
					pin_p_q[gp] <= 1'b0;
				end else begin
					s1_q[gp]    <= pin_raw[gp];
					s2_q[gp]    <= s1_q[gp];
					s3_q[gp]    <= s2_q[gp];
					pin_q[gp]   <= (s2_q[gp] == s3_q[gp]) ? s3_q[gp] : pin_q[gp];
					pin_p_q[gp] <= pin_q[gp];
				end
			end
		end
	endgenerate

	logic sect_rise, wr_rise, gates_on;
	assign sect_rise = (pin_q[0] & ~pin_p_q[0]) | (pin_q[1] & ~pin_p_q[1]);
	assign wr_rise   = pin_q[2] & ~pin_p_q[2];
	assign gates_on  = pin_q[2] | pin_q[3];

	////////////////////////////////////////////////////////////////////////
	// Control state
	logic [4:0] ctrl_q;
	logic       online_q, variant_q, faulted_q, disabled_q, lost_q;
	logic       wp, run_sw, fmt_en, inhibit, avail;
	assign wp      = ctrl_q[`CTRL_WP_BIT];
	assign run_sw  = ctrl_q[`CTRL_RUN_BIT];
	assign fmt_en  = ctrl_q[`CTRL_FMT_BIT];
	assign inhibit = ctrl_q[`CTRL_INHIB_BIT];
	assign avail   = ctrl_q[`CTRL_AVAIL_BIT];

	// APB handshake: one wait state, pready from a flop
	logic        pready_q, pslverr_q, wr_fire, acc, map_ok;
	logic [31:0] prdata_q;
	logic        ctrl_wr, drive_clr, pop_req;
	assign acc       = i_psel & i_penable & ~pready_q;
	assign wr_fire   = i_psel & i_penable & pready_q & i_pwrite & ~pslverr_q;
	assign map_ok    = (i_paddr == `OFS_CTRL) | (i_paddr == `OFS_STATUS) |
	                   (i_paddr == `OFS_LOG_HEAD) | (i_paddr == `OFS_LOG_POP);
	assign ctrl_wr   = wr_fire & (i_paddr == `OFS_CTRL);
	assign drive_clr = ctrl_wr & i_pwdata[`CTRL_CLR_BIT];
	assign pop_req   = wr_fire & (i_paddr == `OFS_LOG_POP);

	////////////////////////////////////////////////////////////////////////
	// Command decode, highest priority source
	logic                     cmd_hit;
	logic [7:0]               cmd_code;
	disk_err_pkg::err_class_e cmd_cls;
	logic                     bad_var;
	assign bad_var = (i_cmd_arg[3:0] != 4'h0) && (i_cmd_arg[3:0] != 4'(SUPP_VAR));

	always_comb begin
		cmd_hit  = 1'b1;
		cmd_code = 8'h00;
		cmd_cls  = disk_err_pkg::PROTOCOL_CLASS;
		if (!i_cmd_valid || i_cmd_op == disk_err_pkg::OP_NOP) begin
			cmd_hit = 1'b0;
		end else if (i_topo_busy && i_cmd_op != disk_err_pkg::OP_TOPOLOGY &&
		             i_cmd_op != disk_err_pkg::OP_GET_STATUS) begin
			cmd_code = `EC_TOPO_BUSY;
		end else begin
			case (i_cmd_op)
				disk_err_pkg::OP_CHANGE_MODE: begin
					if (i_drive_disable_bit) begin
						cmd_code = `EC_DRV_DISABLE;
						cmd_cls  = disk_err_pkg::UNCLASSED;
					end else if (i_cmd_write_en && wp)
						cmd_code = `EC_WP_ENABLE;
					else if (i_cmd_fmt576)
						cmd_code = `EC_FMT_576;
					else if (bad_var)
						cmd_code = `EC_VARIANT;
					else
						cmd_hit = 1'b0;
				end
				disk_err_pkg::OP_SEEK, disk_err_pkg::OP_RECAL: begin
					if (i_cmd_op == disk_err_pkg::OP_SEEK && !online_q)
						cmd_code = `EC_NOT_ONLINE;
					else if (variant_q)
						cmd_code = `EC_VAR_SEEK;
					else if (!run_sw)
						cmd_code = `EC_SPINDLE;
					else if (i_cmd_op == disk_err_pkg::OP_SEEK &&
					         32'(i_cmd_arg) >= 32'(MAX_CYL))
						cmd_code = `EC_CYLINDER;
					else
						cmd_hit = 1'b0;
				end
				disk_err_pkg::OP_ERR_RECOV: begin
					cmd_hit  = 32'(i_cmd_arg) > 32'(MAX_RECOV);
					cmd_code = `EC_RECOV_LVL;
				end
				disk_err_pkg::OP_RUN: begin
					if (!run_sw)
						cmd_code = `EC_RUN_STOP;
					else if (inhibit && (avail || online_q))
						cmd_code = `EC_SPIN_INHIB;
					else
						cmd_hit = 1'b0;
				end
				disk_err_pkg::OP_READ_MEM: begin
					cmd_hit  = 32'(i_cmd_arg) >= 32'(NUM_REGIONS);
					cmd_code = `EC_MEM_REGION;
				end
				disk_err_pkg::OP_DISCONNECT: begin
					cmd_hit  = i_disconnect_modifier_bit;
					cmd_code = `EC_DISC_MOD;
				end
				disk_err_pkg::OP_FMT_TRACK, disk_err_pkg::OP_FMT_SECT: begin
					cmd_hit  = !fmt_en;
					cmd_code = `EC_FMT_DISABLED;
					cmd_cls  = disk_err_pkg::TRANSMISSION_CLASS;
				end
				default: cmd_hit = 1'b0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Timers: controller silence, response stall, clock dropout
	logic [31:0] ctl_cnt_q, resp_cnt_q;
	logic        ctl_drop, resp_to, rw_ready_p_q;
	logic [1:0]  clk_drop;
	assign ctl_drop = online_q && !i_ctl_activity && ctl_cnt_q == 32'(CTL_TO_CYC - 1);
	assign resp_to  = i_resp_valid && !i_resp_ready && resp_cnt_q == 32'(RESP_TO_CYC - 1);

	// Silence and stall counters restart on any progress
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			ctl_cnt_q    <= 32'h0000_0000;
			resp_cnt_q   <= 32'h0000_0000;
			rw_ready_p_q <= 1'b0;
		end else begin
			ctl_cnt_q    <= (!online_q || i_ctl_activity || ctl_drop) ? 32'h0000_0000
			                : ctl_cnt_q + 32'h0000_0001;
			resp_cnt_q   <= (!i_resp_valid || i_resp_ready || resp_to) ? 32'h0000_0000
			                : resp_cnt_q + 32'h0000_0001;
			rw_ready_p_q <= i_rw_ready;
		end
	end

	genvar gc;
	generate
		for (gc = 0; gc < 2; gc++) begin : g_clkmon
			logic [15:0] idle_q;
			assign clk_drop[gc] = i_xfer_active && idle_q == 16'(`DROP_CYC - 1);
			// Idle time since last edge of the synchronised link clock
			always_ff @(posedge i_clk) begin
				if (i_srst)
					idle_q <= 16'h0000;
				else if (!i_xfer_active || pin_q[4+gc] != pin_p_q[4+gc] || clk_drop[gc])
					idle_q <= 16'h0000;
				else
					idle_q <= idle_q + 16'h0001;
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Per-bank single-bit correction counters, saturate one past the limit
	logic [NUM_BANKS-1:0] corr_ovf;
	genvar gb;
	generate
		for (gb = 0; gb < NUM_BANKS; gb++) begin : g_bank
			logic [8:0] cnt_q;
			logic       hit;
			assign hit          = i_corr_valid && i_corr_bank == BW'(gb);
			assign corr_ovf[gb] = hit && cnt_q == `CORR_LIMIT;
			always_ff @(posedge i_clk) begin
				if (i_srst || drive_clr)
					cnt_q <= 9'h000;
				else if (hit && cnt_q <= `CORR_LIMIT)
					cnt_q <= cnt_q + 9'h001;
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Source priority: index 0 wins
	logic [NSRC-1:0]          src_hit;
	logic [7:0]               src_code [NSRC];
	disk_err_pkg::err_class_e src_cls  [NSRC];
	logic                     xfer_bad, rdy_lost;
	assign xfer_bad = i_transfer_cmd_received && (faulted_q || !i_rw_ready);
	assign rdy_lost = i_xfer_active && rw_ready_p_q && !i_rw_ready;

	always_comb begin
		src_hit     = {resp_to, ctl_drop, |clk_drop, wr_rise & wp, sect_rise & gates_on,
		               |corr_ovf, rdy_lost, xfer_bad, cmd_hit};
		src_code[0] = cmd_code;
		src_cls[0]  = cmd_cls;
		src_code[1] = faulted_q ? `EC_XFER_FAULT : `EC_RW_READY;
		src_code[2] = `EC_RW_READY;
		src_code[3] = `EC_CORR_OVF;
		src_code[4] = `EC_OVERRUN;
		src_code[5] = `EC_WP_WRITE;
		src_code[6] = `EC_CLK_DROP;
		src_code[7] = `EC_CTL_DROP;
		src_code[8] = `EC_RESP_TO;
		src_cls[1]  = disk_err_pkg::PROTOCOL_CLASS;
		src_cls[2]  = disk_err_pkg::PROTOCOL_CLASS;
		src_cls[3]  = disk_err_pkg::DRIVE_FAULT_CLASS;
		src_cls[4]  = disk_err_pkg::TRANSMISSION_CLASS;
		src_cls[5]  = disk_err_pkg::WRITE_LOCK_CLASS;
		src_cls[6]  = disk_err_pkg::WRITE_LOCK_CLASS;
		src_cls[7]  = disk_err_pkg::PROTOCOL_CLASS;
		src_cls[8]  = disk_err_pkg::PROTOCOL_CLASS;
	end

	logic [7:0]               sel_code;
	disk_err_pkg::err_class_e sel_cls;
	always_comb begin
		sel_code = 8'h00;
		sel_cls  = disk_err_pkg::PROTOCOL_CLASS;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (src_hit[i]) begin
				sel_code = src_code[i];
				sel_cls  = src_cls[i];
			end
		end
	end

	// Selected error, registered one cycle
	logic                     err_v_q;
	logic [7:0]               err_code_q;
	disk_err_pkg::err_class_e err_cls_q;
	logic                     multi;
	assign multi = |(src_hit & (src_hit - NSRC'(1)));
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			err_v_q    <= 1'b0;
			err_code_q <= 8'h00;
			err_cls_q  <= disk_err_pkg::PROTOCOL_CLASS;
		end else begin
			err_v_q    <= |src_hit;
			err_code_q <= sel_code;
			err_cls_q  <= sel_cls;
		end
	end

	// An overflow with no higher source pending is the registered error next cycle
	AST_CORR_COUNT: assert property (
		|corr_ovf && !cmd_hit && !xfer_bad && !rdy_lost
		|=> err_v_q && err_code_q == `EC_CORR_OVF &&
		err_cls_q == disk_err_pkg::DRIVE_FAULT_CLASS)
		else $error("bank overflow not logged");

	////////////////////////////////////////////////////////////////////////
	// Error log: code plus class, held until software pops it
	logic [10:0]  log_mem [LOG_DEPTH];
	logic [LW-1:0] wp_q, rp_q;
	logic [LW:0]   cnt_q;
	logic          push, pop;
	assign pop  = pop_req && cnt_q != '0;
	assign push = err_v_q && (cnt_q != (LW+1)'(LOG_DEPTH) || pop);

	always_ff @(posedge i_clk) begin
		if (push)
			log_mem[wp_q] <= {err_cls_q, err_code_q};
	end

	// Pointers and occupancy
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			wp_q  <= push ? wp_q + LW'(1) : wp_q;
			rp_q  <= pop ? rp_q + LW'(1) : rp_q;
			cnt_q <= cnt_q + (LW+1)'(push) - (LW+1)'(pop);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Drive state; hardware set wins over software clear
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			ctrl_q     <= `CTRL_RESET;
			online_q   <= 1'b0;
			variant_q  <= 1'b0;
			faulted_q  <= 1'b0;
			disabled_q <= 1'b0;
			lost_q     <= 1'b0;
		end else begin
			if (ctrl_wr)
				ctrl_q <= i_pwdata[4:0];
			if (ctl_drop)
				online_q <= 1'b0;
			else if (ctrl_wr)
				online_q <= i_pwdata[`CTRL_ONLINE_BIT];
			if (i_cmd_valid && i_cmd_op == disk_err_pkg::OP_CHANGE_MODE && !cmd_hit)
				variant_q <= i_cmd_arg[3:0] == 4'(SUPP_VAR);
			if (err_v_q && err_cls_q == disk_err_pkg::DRIVE_FAULT_CLASS)
				faulted_q <= 1'b1;
			else if (drive_clr)
				faulted_q <= 1'b0;
			if (i_cmd_valid && cmd_code == `EC_DRV_DISABLE && cmd_hit)
				disabled_q <= 1'b1;
			else if (drive_clr)
				disabled_q <= 1'b0;
			if (multi || (err_v_q && !push))
				lost_q <= 1'b1;
			else if (drive_clr)
				lost_q <= 1'b0;
		end
	end

	// APB response and read data
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= acc;
			pslverr_q <= acc && !map_ok;
			if (acc) begin
				case (i_paddr)
					`OFS_CTRL:     prdata_q <= {26'h000_0000, online_q, ctrl_q};
					`OFS_STATUS:   prdata_q <= {16'h0000, 8'(cnt_q), 3'h0, lost_q,
					                            disabled_q, variant_q, online_q, faulted_q};
					`OFS_LOG_HEAD: prdata_q <= {cnt_q != '0, 20'h0_0000, log_mem[rp_q]};
					default:       prdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Outputs from flops
	always_ff @(posedge i_clk) begin
		if (i_srst)
			o_resp_abort <= 1'b0;
		else
			o_resp_abort <= resp_to;
	end
	assign o_prdata         = prdata_q;
	assign o_pready         = pready_q;
	assign o_pslverr        = pslverr_q;
	assign o_fault          = faulted_q;
	assign o_online         = online_q;
	assign o_variant_mode   = variant_q;
	assign o_drive_disabled = disabled_q;

	////////////////////////////////////////////////////////////////////////
	// Checks
	AST_WP_ENABLE: assert property (
		i_cmd_valid && i_cmd_op == disk_err_pkg::OP_CHANGE_MODE && !i_topo_busy &&
		!i_drive_disable_bit && i_cmd_write_en && wp
		|=> err_v_q && err_code_q == 8'h0F && err_cls_q == disk_err_pkg::PROTOCOL_CLASS)
		else $error("write enable under protect not flagged");
	AST_XFER_FAULT: assert property (
		!cmd_hit && i_transfer_cmd_received && faulted_q |=> err_code_q == 8'h12)
		else $error("transfer while faulted not flagged");
	AST_VAR_SEEK: assert property (
		i_cmd_valid && i_cmd_op == disk_err_pkg::OP_RECAL && !i_topo_busy && variant_q
		|=> err_v_q && err_code_q == 8'h17)
		else $error("recal in variant mode not flagged");
	AST_SPINDLE: assert property (
		i_cmd_valid && i_cmd_op == disk_err_pkg::OP_RECAL && !i_topo_busy && !variant_q &&
		!run_sw |=> err_code_q == 8'h2C)
		else $error("recal with spindle stopped not flagged");
	AST_FMT_OFF: assert property (
		cmd_hit && cmd_code == 8'h44
		|=> err_cls_q == disk_err_pkg::TRANSMISSION_CLASS)
		else $error("format without enable wrong class");
	AST_FAULT_LED: assert property (
		err_v_q && err_cls_q == disk_err_pkg::DRIVE_FAULT_CLASS
		|=> o_fault ##1 (o_fault || $past(drive_clr)))
		else $error("drive fault did not light fault output");
	AST_NO_FAULT: assert property (
		!faulted_q && (!err_v_q || err_cls_q != disk_err_pkg::DRIVE_FAULT_CLASS) |=> !o_fault)
		else $error("fault output set without drive fault");
	AST_DISABLE: assert property (
		i_cmd_valid && i_cmd_op == disk_err_pkg::OP_CHANGE_MODE && !i_topo_busy &&
		i_drive_disable_bit |=> err_code_q == 8'h4A && o_drive_disabled)
		else $error("drive disable not taken");
	AST_LOG_HOLD: assert property (
		cnt_q != '0 && !pop_req |=> cnt_q != '0 && rp_q == $past(rp_q))
		else $error("log entry lost without clear");
	AST_RESP_TO: assert property (
		resp_to |=> o_resp_abort ##1 !o_resp_abort)
		else $error("response timeout not signalled once");

endmodule

`default_nettype wire

/* File: verification/host_ctrl_model.sv */
// Host controller stand-in: sends decoded commands, answers responses.
// Assumes the bench calls issue right after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module host_ctrl_model (
	input  wire logic                 i_clk,
	input  wire logic                 i_stall,
	input  wire logic                 i_resp_valid,
	output var logic                  o_cmd_valid,
	output var disk_err_pkg::cmd_op_e o_cmd_op,
	output var logic [15:0]           o_cmd_arg,
	output var logic [3:0]            o_mods,
	output logic                      o_activity,
	output logic                      o_resp_ready
);
	logic [2:0] tick_q = 3'h0;
	initial {o_cmd_valid, o_cmd_arg, o_mods} = '0;
	initial o_cmd_op = disk_err_pkg::OP_NOP;
	// Controller shows life every eighth cycle, silent while stalled
	always_ff @(posedge i_clk) tick_q <= tick_q + 3'h1;
	assign o_activity = tick_q == 3'h0 && !i_stall;
	// Takes responses at once unless stalled
	assign o_resp_ready = i_resp_valid & ~i_stall;
	// One command for one cycle; argument and modifiers inverted after, opcode held
	task issue(input logic [3:0] op, input logic [15:0] a, input logic [3:0] m);
		o_cmd_valid <= 1'h1;
		o_cmd_op <= disk_err_pkg::cmd_op_e'(op);
		o_cmd_arg <= a;
		o_mods <= m;
		@(posedge i_clk) o_cmd_valid <= 1'h0;
		o_cmd_arg <= ~a;
		o_mods <= ~m;
	endtask
endmodule
`default_nettype wire

/* File: verification/test_disk_cmd_error_checker.sv */
// Bench for the command error checker: command table, then hand cases.
// Assumes the package and the host model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module test_disk_cmd_error_checker;
	typedef struct {logic [3:0] op; logic [15:0] a; logic [4:0] m; logic [8:0] c; logic [10:0] e;} row_s;
	logic        clk, srst, psel, penable, pwrite, pready, pslverr, serr, cmd_valid;
	logic        xfer_rx, rw_ready, topo, act, resp_valid, resp_ready, stall;
	logic        corr_valid, wr_gate, fault, abort, dis, onl, var_m, xfer_act, sect, lclk;
	logic [3:0]  mods;
	logic [7:0]  paddr;
	logic [15:0] cmd_arg;
	logic [31:0] pwdata, prdata, rd;
	int          n_errors, n_tests, k;
	row_s        rows[16];
	disk_err_pkg::cmd_op_e cmd_op;
	// Device with shortened timeouts
	disk_cmd_error_checker #(.RESP_TO_CYC(16), .CTL_TO_CYC(32)) u_disk_cmd_error_checker (
		.i_clk(clk), .i_srst(srst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .i_cmd_valid(cmd_valid), .i_cmd_op(cmd_op), .i_cmd_arg(cmd_arg),
		.i_cmd_write_en(mods[0]), .i_cmd_fmt576(mods[1]), .i_drive_disable_bit(mods[2]),
		.i_disconnect_modifier_bit(mods[3]), .i_transfer_cmd_received(xfer_rx),
		.i_xfer_active(xfer_act), .i_rw_ready(rw_ready), .i_topo_busy(topo),
		.i_ctl_activity(act), .i_resp_valid(resp_valid), .i_resp_ready(resp_ready),
		.i_corr_valid(corr_valid), .i_corr_bank(3'h0), .i_sector_pin(sect),
		.i_index_pin(1'h0), .i_wr_gate_pin(wr_gate), .i_rd_gate_pin(1'h0),
		.i_ctl_clk_pin(lclk), .i_dat_clk_pin(lclk), .o_fault(fault), .o_online(onl),
		.o_variant_mode(var_m), .o_drive_disabled(dis), .o_resp_abort(abort));
	host_ctrl_model u_host_ctrl_model (.i_clk(clk), .i_stall(stall), .i_resp_valid(resp_valid),
		.o_cmd_valid(cmd_valid), .o_cmd_op(cmd_op), .o_cmd_arg(cmd_arg), .o_mods(mods),
		.o_activity(act), .o_resp_ready(resp_ready));
	////////////////////////////////////////////////////////////////////////////////
	// Counts and closes the run
	task stop_test;
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Compare one value
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask
	// One APB transfer, bounded wait for pready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk) penable <= 1'h1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'h1 && k < 50);
		rd = prdata;
		serr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
		if (k >= 50) begin
			n_errors++;
			stop_test;
		end
	endtask
	// Read log head, compare, pop
	task chk_log(input logic [10:0] e);
		apb(1'h0, 8'h08, 32'h0);
		chk("log head", {1'h1, 20'h0_0000, e}, rd);
		apb(1'h1, 8'h0C, 32'h0);
	endtask
	// Level 1 transfer command pulse
	task xfer(input logic r);
		rw_ready <= r;
		xfer_rx <= 1'h1;
		@(posedge clk) xfer_rx <= 1'h0;
		repeat (3) @(posedge clk);
	endtask
	always #2 clk = ~clk;
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{clk, psel, penable, pwrite, paddr, pwdata, xfer_rx, rw_ready, topo} = '0;
		{resp_valid, stall, corr_valid, wr_gate, xfer_act, sect, lclk, n_errors, n_tests} = '0;
		srst = 1'h1;
		rows = '{'{4'h1, 16'h0, 5'h01, 9'h001, 11'h20F},
			'{4'h1, 16'h0, 5'h02, 9'h000, 11'h215},
			'{4'h1, 16'h2, 5'h0, 9'h0, 11'h216},
			'{4'h2, 16'h0, 5'h0, 9'h002, 11'h242},
			'{4'h2, 16'h0400, 5'h0, 9'h022, 11'h21A},
			'{4'h2, 16'h0, 5'h0, 9'h020, 11'h22C},
			'{4'h3, 16'h0, 5'h0, 9'h020, 11'h22C},
			'{4'h4, 16'h4, 5'h0, 9'h0, 11'h229},
			'{4'h5, 16'h0, 5'h0, 9'h0, 11'h22F},
			'{4'h5, 16'h0, 5'h0, 9'h01A, 11'h22E},
			'{4'h6, 16'h4, 5'h0, 9'h0, 11'h240},
			'{4'h7, 16'h0, 5'h08, 9'h0, 11'h247},
			'{4'h9, 16'h0, 5'h0, 9'h0, 11'h144},
			'{4'hA, 16'h0, 5'h0, 9'h0, 11'h144},
			'{4'h2, 16'h0, 5'h10, 9'h022, 11'h249},
			'{4'h1, 16'h0, 5'h04, 9'h0, 11'h54A}};
		repeat (12) @(posedge clk);
		srst <= 1'h0;
		apb(1'h0, 8'h04, 32'h0);
		chk("status after reset", 32'h0, rd);
		apb(1'h0, 8'h10, 32'h0);
		chk("unmapped slverr", 32'h1, {31'h0, serr});
		// Table of command cases
		foreach (rows[i]) begin
			apb(1'h1, 8'h00, {23'h0, rows[i].c} | 32'h0000_0100);
			topo <= rows[i].m[4];
			u_host_ctrl_model.issue(rows[i].op, rows[i].a, rows[i].m[3:0]);
			repeat (3) @(posedge clk);
			chk_log(rows[i].e);
		end
		chk("fault", 32'h0, {31'h0, fault});
		chk("disabled", 32'h1, {31'h0, dis});
		// Variant mode refuses recalibrate
		u_host_ctrl_model.issue(4'h1, 16'h1, 4'h0);
		repeat (3) @(posedge clk);
		chk("variant", 32'h1, {31'h0, var_m});
		u_host_ctrl_model.issue(4'h3, 16'h0, 4'h0);
		repeat (3) @(posedge clk);
		chk_log(11'h217);
		u_host_ctrl_model.issue(4'h1, 16'h0, 4'h0);
		// Correction count boundary
		apb(1'h1, 8'h00, 32'h0000_0100);
		corr_valid <= 1'h1;
		repeat (256) @(posedge clk);
		corr_valid <= 1'h0;
		repeat (4) @(posedge clk);
		chk("fault at 256", 32'h0, {31'h0, fault});
		corr_valid <= 1'h1;
		@(posedge clk) corr_valid <= 1'h0;
		repeat (4) @(posedge clk);
		chk("fault at 257", 32'h1, {31'h0, fault});
		chk_log(11'h01E);
		xfer(1'h1);
		chk_log(11'h212);
		apb(1'h1, 8'h00, 32'h0000_0100);
		xfer(1'h0);
		chk_log(11'h243);
		// Write gate while protected, then a sector pulse inside the gate
		apb(1'h1, 8'h00, 32'h0000_0001);
		wr_gate <= 1'h1;
		repeat (8) @(posedge clk);
		sect <= 1'h1;
		repeat (8) @(posedge clk);
		{sect, wr_gate} <= 2'h0;
		chk_log(11'h34E);
		chk_log(11'h11F);
		// Link clocks run during a transfer, then stop
		xfer_act <= 1'h1;
		for (k = 0; k < 320; k++) @(posedge clk) lclk <= lclk ^ (k[1:0] == 2'h0);
		apb(1'h0, 8'h04, 32'h0);
		chk("no early dropout", 32'h0, rd & 32'h0000_ff00);
		repeat (260) @(posedge clk);
		xfer_act <= 1'h0;
		chk_log(11'h34F);
		// Controller refuses a response
		stall <= 1'h1;
		resp_valid <= 1'h1;
		for (k = 0; k < 40 && abort !== 1'h1; k++) @(posedge clk);
		chk("response abort", 32'h1, {31'h0, abort});
		resp_valid <= 1'h0;
		stall <= 1'h0;
		repeat (3) @(posedge clk);
		chk_log(11'h241);
		// Silent controller is dropped
		apb(1'h1, 8'h00, 32'h0000_0020);
		chk("online", 32'h1, {31'h0, onl});
		stall <= 1'h1;
		repeat (48) @(posedge clk);
		stall <= 1'h0;
		chk("online dropped", 32'h0, {31'h0, onl});
		chk_log(11'h21D);
		stop_test;
	end
endmodule
`default_nettype wire
